// ---- rtl/fan_monitor_regs.svh ----
`ifndef FAN_MONITOR_REGS_SVH
`define FAN_MONITOR_REGS_SVH

// Fixed 7-bit serial bus address
`define SMB_DEV_ADDR 7'h2E

// Register offsets
`define REG_TEMP_READ 8'h26
`define REG_FAN_DUTY0 8'h30
`define REG_MAX_DUTY 8'h38
`define REG_STATUS2 8'h42
`define REG_LF_FREQ 8'h5F
`define REG_THERMAL_LIMIT_PIN_LIMIT 8'h6A
`define REG_TEMP_OFFSET 8'h70
`define REG_EXT_CFG 8'h7C
`define REG_PIN_FN 8'h7D

// Reset values
`define RST_EXT_CFG 8'h00
`define RST_PIN_FN 8'h00
`define RST_THERMAL_LIMIT_PIN_LIMIT 8'hA4
`define RST_MAX_DUTY 8'hFF
`define RST_FAN_DUTY 8'h00
`define RST_LF_FREQ 8'h01
`define RST_TEMP_OFFSET 8'h00

// Field positions and limits
`define STAT2_OVERTEMP_BIT 0
`define STAT2_TIMEOUT_BIT 1
`define STAT2_SHARED_PIN_BIT 5
`define LF_FREQ_MIN 8'h01
`define LF_FREQ_MAX 8'h0A
`define FULL_DUTY 8'hFF

// Timing
`define CLK_HZ 125000000
`define FAST_DRIVE_HZ 22500
`define LF_STEP_HZ 10
`define FAILSAFE_MS 4600
`define NUM_FANS 3

`endif

// ---- rtl/fan_monitor_pkg.sv ----
package fan_monitor_pkg;

	// Role of the shared pin, in register encoding order
	typedef enum logic [1:0] {PIN_FAN4_SPEED_INPUT, PIN_THERMAL, PIN_ALERT, PIN_GPIO} pin_fn_t;

	// Serial bus slave states
	typedef enum logic [1:0] {SMB_IDLE, SMB_ADDR, SMB_WRITE, SMB_READ} smb_state_t;

	// Extended configuration register layout
	typedef struct packed {
		logic [2:0] reserved;
		logic gpio_level;
		logic gpio_active_high;
		logic gpio_is_output;
		logic slow_drive;
		logic twos_range;
	} ext_cfg_t;

	// Pin synchroniser bundle
	typedef struct packed {
		logic tgl;
		logic pin;
		logic core;
		logic sda;
		logic scl;
	} pin_sync_t;

endpackage : fan_monitor_pkg

// ---- rtl/fan_monitor_config_failsafe.sv ----
`timescale 1ns/10ps
`include "fan_monitor_regs.svh"

module fan_monitor_config_failsafe #(
	parameter int unsigned FAILSAFE_CYCLES = `FAILSAFE_MS * (`CLK_HZ / 1000)
) (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Serial bus pins
	input wire logic smb_scl,
	input wire logic smb_sda_in,
	output logic smb_sda_out,
	output logic smb_sda_oe,
	// Supply and measurement
	input wire logic core_voltage_rail,
	input wire logic [7:0] temp_code,
	output logic monitor_go_bit,
	// Fan drive
	output logic [`NUM_FANS-1:0] fan_drive,
	// Shared pin
	input wire logic shared_pin_in,
	output logic shared_pin_out,
	output logic shared_pin_oe,
	output logic fan4_speed_input,
	output logic processor_hot_signal
);
	import fan_monitor_pkg::*;

	localparam logic [31:0] FAST_INC = 32'(((64'd1 << 32) * `FAST_DRIVE_HZ) / `CLK_HZ);
	localparam logic [31:0] LF_UNIT_INC = 32'(((64'd1 << 32) * `LF_STEP_HZ) / `CLK_HZ);

	// Fan duty register window decode, shared by read and write paths
	function automatic logic fan_hit(input logic [7:0] ptr);
		fan_hit = (ptr >= `REG_FAN_DUTY0) && (ptr < (`REG_FAN_DUTY0 + 8'(`NUM_FANS)));
	endfunction : fan_hit

	function automatic logic [1:0] fan_idx(input logic [7:0] ptr);
		logic [7:0] diff;
		diff = ptr - `REG_FAN_DUTY0;
		fan_idx = diff[1:0];
	endfunction : fan_idx

	// Compare in whichever coding the range bit selects
	function automatic logic temp_above(input logic twos, input logic [7:0] t,
		input logic [7:0] lim);
		if (twos) begin
			temp_above = $signed(t) > $signed(lim);
		end else begin
			temp_above = t > lim;
		end
	endfunction : temp_above

	// Link-side sampler, clocked by the bus clock itself
	logic [7:0] link_shift = 8'h00;
	logic link_tgl = 1'b0;

	// Each rising bus clock shifts in one data bit
	always_ff @(posedge smb_scl) begin
		link_shift <= {link_shift[6:0], smb_sda_in};
	end

	// Toggle announces each new bit to the system domain
	always_ff @(posedge smb_scl) begin
		link_tgl <= ~link_tgl;
	end

	// Two-stage synchronisers for every asynchronous input
	pin_sync_t sync_a;
	pin_sync_t sync_b;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= '{tgl: link_tgl, pin: shared_pin_in, core: core_voltage_rail,
				sda: smb_sda_in, scl: smb_scl};
			sync_b <= sync_a;
		end
	end

	// Delayed copies for edge detection; only the second stage is read
	logic scl_q;
	logic sda_q;
	logic tgl_q;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			scl_q <= 1'b0;
			sda_q <= 1'b0;
			tgl_q <= 1'b0;
		end else begin
			scl_q <= sync_b.scl;
			sda_q <= sync_b.sda;
			tgl_q <= sync_b.tgl;
		end
	end

	logic start_ev;
	logic stop_ev;
	logic scl_fall;
	logic bit_ev;
	assign start_ev = sync_b.scl & scl_q & sda_q & ~sync_b.sda;
	assign stop_ev = sync_b.scl & scl_q & ~sda_q & sync_b.sda;
	assign scl_fall = scl_q & ~sync_b.scl;
	assign bit_ev = sync_b.tgl ^ tgl_q;

	// Captured word: link shift is stable for a full bus bit after the toggle
	logic [7:0] rx;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			rx <= 8'h00;
		end else if (bit_ev) begin
			rx <= link_shift;
		end
	end

	// Bit counting within a nine-clock byte slot
	logic [3:0] bitcnt;
	logic byte_done;
	logic ninth_done;
	always_ff @(posedge clk_sys) begin
		if (sys_rst || start_ev || stop_ev) begin
			bitcnt <= 4'h0;
			byte_done <= 1'b0;
			ninth_done <= 1'b0;
		end else begin
			byte_done <= bit_ev && (bitcnt == 4'h7);
			ninth_done <= bit_ev && (bitcnt == 4'h8);
			if (bit_ev) begin
				bitcnt <= (bitcnt == 4'h8) ? 4'h0 : bitcnt + 4'h1;
			end
		end
	end

	// Slave protocol: address match, pointer load, register write
	smb_state_t st;
	logic ack_due;
	logic rd_go;
	logic first_byte;
	logic engaged;
	logic wr_pulse;
	logic addr_hit;
	logic xfer_done;
	logic [7:0] pointer;
	always_ff @(posedge clk_sys) begin
		wr_pulse <= 1'b0;
		addr_hit <= 1'b0;
		xfer_done <= 1'b0;
		if (sys_rst) begin
			st <= SMB_IDLE;
			ack_due <= 1'b0;
			rd_go <= 1'b0;
			first_byte <= 1'b0;
			engaged <= 1'b0;
			pointer <= 8'h00;
		end else if (start_ev) begin
			st <= SMB_ADDR;
			ack_due <= 1'b0;
		end else if (stop_ev) begin
			st <= SMB_IDLE;
			ack_due <= 1'b0;
			engaged <= 1'b0;
			xfer_done <= engaged;
		end else if (byte_done) begin
			case (st)
				SMB_ADDR: begin
					if (rx[7:1] == `SMB_DEV_ADDR) begin
						ack_due <= 1'b1;
						addr_hit <= 1'b1;
						engaged <= 1'b1;
						rd_go <= rx[0];
						first_byte <= 1'b1;
						st <= rx[0] ? SMB_READ : SMB_WRITE;
					end else begin
						st <= SMB_IDLE;
					end
				end
				SMB_WRITE: begin
					ack_due <= 1'b1;
					first_byte <= 1'b0;
					if (first_byte) begin
						pointer <= rx;
					end else begin
						wr_pulse <= 1'b1;
					end
				end
				default: begin
				end
			endcase
		end else if (ninth_done && (st == SMB_READ)) begin
			rd_go <= ~rx[0]; // Master NACK ends the read
		end else if (scl_fall) begin
			ack_due <= 1'b0;
		end
	end

	// Register file
	ext_cfg_t ext_cfg;
	logic [7:0] pin_function_config;
	logic [7:0] thermal_limit_pin_limit;
	logic [7:0] temp_offset;
	logic [7:0] max_duty;
	logic [7:0] lf_freq;
	logic [7:0] fan_duty [`NUM_FANS];

	// Writes land one cycle after the data byte; read-only offsets ignore them
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			ext_cfg <= ext_cfg_t'(`RST_EXT_CFG);
			pin_function_config <= `RST_PIN_FN;
			thermal_limit_pin_limit <= `RST_THERMAL_LIMIT_PIN_LIMIT;
			temp_offset <= `RST_TEMP_OFFSET;
			max_duty <= `RST_MAX_DUTY;
			lf_freq <= `RST_LF_FREQ;
			for (int i = 0; i < `NUM_FANS; i++) begin
				fan_duty[i] <= `RST_FAN_DUTY;
			end
		end else if (wr_pulse) begin
			case (pointer)
				`REG_EXT_CFG: ext_cfg <= ext_cfg_t'({3'h0, rx[4:0]});
				`REG_PIN_FN: pin_function_config <= {6'h00, rx[1:0]};
				`REG_THERMAL_LIMIT_PIN_LIMIT: thermal_limit_pin_limit <= rx;
				`REG_TEMP_OFFSET: temp_offset <= rx;
				`REG_MAX_DUTY: max_duty <= rx;
				`REG_LF_FREQ: begin
					// Out-of-range codes clamp into the 10..100 Hz span
					if (rx < `LF_FREQ_MIN) begin
						lf_freq <= `LF_FREQ_MIN;
					end else if (rx > `LF_FREQ_MAX) begin
						lf_freq <= `LF_FREQ_MAX;
					end else begin
						lf_freq <= rx;
					end
				end
				default: begin
					if (fan_hit(pointer)) begin
						fan_duty[fan_idx(pointer)] <= rx;
					end
				end
			endcase
		end
	end

	// Monitoring start, sticky once reached
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			monitor_go_bit <= 1'b0;
		end else if (sync_b.core || xfer_done) begin
			monitor_go_bit <= 1'b1;
		end
	end

	// Programmed state and address history
	logic programmed;
	logic addressed_once;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			programmed <= 1'b0;
			addressed_once <= 1'b0;
		end else begin
			if (wr_pulse) begin
				programmed <= 1'b1;
			end
			if (addr_hit) begin
				addressed_once <= 1'b1;
			end
		end
	end

	// Bus-silence watchdog; runs only with the core rail up
	logic [31:0] fs_count;
	logic timeout_fs;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fs_count <= 32'h0000_0000;
			timeout_fs <= 1'b0;
		end else if (wr_pulse) begin
			timeout_fs <= 1'b0;
		end else if (sync_b.core && !addressed_once && !addr_hit && !timeout_fs) begin
			fs_count <= fs_count + 32'h0000_0001;
			if (fs_count == (FAILSAFE_CYCLES - 32'd1)) begin
				timeout_fs <= 1'b1;
			end
		end
	end

	// Offset in half-degree counts; sum wraps, so keep offsets sane near range ends
	logic [7:0] adj_temp;
	logic overtemp;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			adj_temp <= 8'h00;
			overtemp <= 1'b0;
		end else begin
			adj_temp <= temp_code + 8'($signed(temp_offset) >>> 1);
			overtemp <= monitor_go_bit &&
				temp_above(ext_cfg.twos_range, adj_temp, thermal_limit_pin_limit);
		end
	end

	logic full_speed;
	assign full_speed = overtemp | timeout_fs;

	// One shared phase accumulator keeps all fan outputs in step
	logic [31:0] phase;
	logic [31:0] phase_inc;
	always_comb begin
		if (ext_cfg.slow_drive) begin
			phase_inc = 32'(LF_UNIT_INC * lf_freq);
		end else begin
			phase_inc = FAST_INC;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			phase <= 32'h0000_0000;
		end else begin
			phase <= phase + phase_inc;
		end
	end

	// Per-fan duty selection and comparison
	logic [`NUM_FANS-1:0] next_fan_drive;
	generate
		for (genvar g = 0; g < `NUM_FANS; g++) begin : g_fan
			logic [7:0] duty;
			always_comb begin
				if (full_speed) begin
					duty = `FULL_DUTY;
				end else if (programmed) begin
					duty = (fan_duty[g] > max_duty) ? max_duty : fan_duty[g];
				end else begin
					duty = 8'h00;
				end
				next_fan_drive[g] = (duty == `FULL_DUTY) || (phase[31:24] < duty);
			end
		end
	endgenerate

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			fan_drive <= '0;
		end else begin
			fan_drive <= next_fan_drive;
		end
	end

	// Shared pin function and the level it reports
	pin_fn_t pin_fn;
	logic shared_bit;
	assign pin_fn = pin_fn_t'(pin_function_config[1:0]);
	always_comb begin
		case (pin_fn)
			PIN_GPIO: shared_bit = (sync_b.pin == ext_cfg.gpio_active_high);
			PIN_THERMAL: shared_bit = ~sync_b.pin;
			default: shared_bit = sync_b.pin;
		endcase
	end

	// Open-drain drive: only ever pulls low
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			shared_pin_out <= 1'b0;
			shared_pin_oe <= 1'b0;
			fan4_speed_input <= 1'b0;
			processor_hot_signal <= 1'b0;
		end else begin
			shared_pin_out <= 1'b0;
			case (pin_fn)
				PIN_THERMAL: shared_pin_oe <= overtemp;
				PIN_ALERT: shared_pin_oe <= overtemp | timeout_fs;
				PIN_GPIO: shared_pin_oe <= ext_cfg.gpio_is_output &
					(ext_cfg.gpio_level ^ ext_cfg.gpio_active_high);
				default: shared_pin_oe <= 1'b0;
			endcase
			fan4_speed_input <= (pin_fn == PIN_FAN4_SPEED_INPUT) & sync_b.pin;
			// Own drive would read back as a hot processor, so mask it
			processor_hot_signal <= (pin_fn == PIN_THERMAL) & ~sync_b.pin & ~shared_pin_oe;
		end
	end

	// Read data for the pointed register
	logic [7:0] rdata;
	always_comb begin
		rdata = 8'h00;
		case (pointer)
			`REG_TEMP_READ: rdata = adj_temp;
			`REG_EXT_CFG: rdata = 8'(ext_cfg);
			`REG_PIN_FN: rdata = pin_function_config;
			`REG_THERMAL_LIMIT_PIN_LIMIT: rdata = thermal_limit_pin_limit;
			`REG_TEMP_OFFSET: rdata = temp_offset;
			`REG_MAX_DUTY: rdata = max_duty;
			`REG_LF_FREQ: rdata = lf_freq;
			`REG_STATUS2: begin
				rdata[`STAT2_OVERTEMP_BIT] = overtemp;
				rdata[`STAT2_TIMEOUT_BIT] = timeout_fs;
				rdata[`STAT2_SHARED_PIN_BIT] = shared_bit;
			end
			default: begin
				if (fan_hit(pointer)) begin
					rdata = fan_duty[fan_idx(pointer)];
				end
			end
		endcase
	end

	// Data line driver; changes after a falling bus clock or clears on start and stop, so data is stable while the clock is high
	logic [7:0] tx;
	always_ff @(posedge clk_sys) begin
		smb_sda_out <= 1'b0;
		if (sys_rst || start_ev || stop_ev) begin
			smb_sda_oe <= 1'b0;
			tx <= 8'h00;
		end else if (scl_fall) begin
			if (ack_due) begin
				smb_sda_oe <= 1'b1;
			end else if ((st == SMB_READ) && (bitcnt == 4'h0) && rd_go) begin
				tx <= {rdata[6:0], 1'b0};
				smb_sda_oe <= ~rdata[7];
			end else if ((st == SMB_READ) && (bitcnt != 4'h0) && (bitcnt != 4'h8)) begin
				tx <= {tx[6:0], 1'b0};
				smb_sda_oe <= ~tx[7];
			end else begin
				smb_sda_oe <= 1'b0;
			end
		end
	end

endmodule : fan_monitor_config_failsafe

// ---- verification/fan_monitor_config_failsafe_chk.sv ----
`timescale 1ns/10ps
`include "fan_monitor_regs.svh"

module fan_monitor_config_failsafe_chk #(
	parameter int unsigned FAILSAFE_CYCLES = 200
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Bus and supply
	input wire logic smb_scl,
	input wire logic smb_sda_oe,
	input wire logic core_voltage_rail,
	// Outputs under watch
	input wire logic monitor_go_bit,
	input wire logic [`NUM_FANS-1:0] fan_drive,
	input wire logic shared_pin_in,
	input wire logic shared_pin_out,
	input wire logic fan4_speed_input,
	input wire logic processor_hot_signal
);
	logic seen_bus;
	logic seen_rail;
	logic [31:0] idle_cnt;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	// Sticky flags: any bus clock low or rail high since reset
	always_ff @(posedge clk_sys) begin
		seen_bus <= sys_rst ? 1'b0 : (seen_bus | ~smb_scl);
		seen_rail <= sys_rst ? 1'b0 : (seen_rail | core_voltage_rail);
	end

	// Rail-up cycles with an untouched bus; saturates so it never wraps
	always_ff @(posedge clk_sys) begin
		if (sys_rst || seen_bus) begin
			idle_cnt <= '0;
		end else if (core_voltage_rail && idle_cnt < FAILSAFE_CYCLES + 8) begin
			idle_cnt <= idle_cnt + 1;
		end
	end

	a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
		fan_drive == '0 && !smb_sda_oe && !monitor_go_bit) else $error("outputs busy after reset");
	a_fans_idle_off: assert property (!seen_bus && !seen_rail |-> fan_drive == '0)
		else $error("fan driven before programming");
	a_go_sticky: assert property (monitor_go_bit |=> monitor_go_bit)
		else $error("monitoring stopped");
	a_go_on_rail: assert property (core_voltage_rail [*4] |-> ##[0:4] monitor_go_bit)
		else $error("monitoring not started by rail");
	a_timeout_full: assert property (idle_cnt == FAILSAFE_CYCLES + 8 |-> &fan_drive)
		else $error("no full drive after bus silence");
	a_ack_scl_low: assert property ($changed(smb_sda_oe) |-> !smb_scl)
		else $error("data pin moved while bus clock high");
	a_tach_follows: assert property ($rose(fan4_speed_input) |-> $past(shared_pin_in, 2)
		|| $past(shared_pin_in, 3) || $past(shared_pin_in, 4)) else $error("tach rose on low pin");
	a_hot_pin_low: assert property ($rose(processor_hot_signal) |-> !$past(shared_pin_in, 2)
		|| !$past(shared_pin_in, 3) || !$past(shared_pin_in, 4)) else $error("hot flag on high pin");
	a_pin_out_low: assert property (shared_pin_out == 1'b0)
		else $error("shared pin driven high");
endmodule : fan_monitor_config_failsafe_chk

bind fan_monitor_config_failsafe fan_monitor_config_failsafe_chk #(
	.FAILSAFE_CYCLES(FAILSAFE_CYCLES)) chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.smb_scl(smb_scl), .smb_sda_oe(smb_sda_oe), .core_voltage_rail(core_voltage_rail),
	.monitor_go_bit(monitor_go_bit), .fan_drive(fan_drive), .shared_pin_in(shared_pin_in),
	.shared_pin_out(shared_pin_out), .fan4_speed_input(fan4_speed_input),
	.processor_hot_signal(processor_hot_signal));

// ---- verification/smb_host_model.sv ----
`timescale 1ns/10ps

module smb_host_model (
	// Wire side of the bus master
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// Ten link steps per bit, so the system clock sees every edge
	localparam time Q = 12;

	// Bus idle: clock high and data released
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Start or repeated start: data falls while the clock is high
	task automatic start_cond;
		#(2*Q) sda_low = 1'b0;
		#(3*Q) scl = 1'b1;
		#(5*Q) sda_low = 1'b1;
		#(5*Q) scl = 1'b0;
	endtask : start_cond

	// Stop: data rises while the clock is high; clock then stands still
	task automatic stop_cond;
		#(2*Q) sda_low = 1'b1;
		#(3*Q) scl = 1'b1;
		#(5*Q) sda_low = 1'b0;
		#(5*Q);
	endtask : stop_cond

	// One bit; data is set in the low phase and sampled at the rising edge
	task automatic clk_bit(input logic b, output logic s);
		#(2*Q) sda_low = ~b;
		#(3*Q) scl = 1'b1;
		s = sda;
		#(5*Q) scl = 1'b0;
	endtask : clk_bit

	// Eight bits MSB first, then the acknowledge slot
	task automatic xfer_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(d[i], q[i]);
		end
		clk_bit(1'b1, s);
		ack = ~s;
	endtask : xfer_byte

	// Pointer byte, then one data byte
	task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2;
		start_cond();
		xfer_byte({dev, 1'b0}, q, a0);
		xfer_byte(ptr, q, a1);
		xfer_byte(d, q, a2);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : write_reg

	// Pointer set, repeated start, one byte read and refused with a no-acknowledge
	task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic a0, a1, a2, an;
		start_cond();
		xfer_byte({dev, 1'b0}, q, a0);
		xfer_byte(ptr, q, a1);
		start_cond();
		xfer_byte({dev, 1'b1}, q, a2);
		xfer_byte(8'hFF, d, an);
		stop_cond();
		ok = a0 & a1 & a2;
	endtask : read_reg
endmodule : smb_host_model

// ---- verification/test_fan_monitor_config_failsafe.sv ----
`timescale 1ns/10ps
`include "fan_monitor_regs.svh"

module test_fan_monitor_config_failsafe;
	import fan_monitor_pkg::*;
	localparam int unsigned FS = 200;
	logic clk_sys, sys_rst, core_voltage_rail, pin_ext, smb_sda_in, smb_sda_out, smb_sda_oe;
	logic monitor_go_bit, shared_pin_in, shared_pin_out, shared_pin_oe, fan4_speed_input;
	logic processor_hot_signal, scl, host_low, ok;
	logic [7:0] temp_code, rd;
	logic [`NUM_FANS-1:0] fan_drive;
	logic [7:0] gcfg [4] = '{8'h14, 8'h1C, 8'h0C, 8'h18};
	logic goe [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
	int n_mismatch, num_checks, cycles, hi, tr;

	// Open-drain wires with pull-ups
	assign smb_sda_in = ~(smb_sda_oe | host_low);
	assign shared_pin_in = shared_pin_oe ? 1'b0 : pin_ext;

	fan_monitor_config_failsafe #(.FAILSAFE_CYCLES(FS)) uut (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .smb_scl(scl), .smb_sda_in(smb_sda_in), .smb_sda_out(smb_sda_out),
		.smb_sda_oe(smb_sda_oe), .core_voltage_rail(core_voltage_rail), .temp_code(temp_code),
		.monitor_go_bit(monitor_go_bit), .fan_drive(fan_drive), .shared_pin_in(shared_pin_in),
		.shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
		.fan4_speed_input(fan4_speed_input), .processor_hot_signal(processor_hot_signal));

	smb_host_model host (.scl(scl), .sda_low(host_low), .sda(smb_sda_in));

	// System clock, 8 ns
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc

	task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
		host.write_reg(`SMB_DEV_ADDR, ptr, d, ok);
		check("write ack", 8'h01, 8'(ok));
	endtask : wr

	task automatic rdc(input logic [7:0] ptr, input logic [7:0] mask, input logic [7:0] exp);
		host.read_reg(`SMB_DEV_ADDR, ptr, rd, ok);
		check("read ack", 8'h01, 8'(ok));
		check("register value", exp, rd & mask);
	endtask : rdc

	task automatic temp_to(input logic [7:0] v);
		@(posedge clk_sys);
		temp_code <= v;
		cyc(8);
	endtask : temp_to

	// High cycles and transitions of fan 0 over a window
	task automatic watch_fan(input int n);
		logic last;
		hi = 0;
		tr = 0;
		last = fan_drive[0];
		repeat (n) begin
			@(posedge clk_sys);
			#1;
			hi += int'(fan_drive[0]);
			tr += int'(fan_drive[0] != last);
			last = fan_drive[0];
		end
	endtask : watch_fan

	// Hang guard well above the expected run length
	initial begin
		cycles = 0;
		forever begin
			@(posedge clk_sys);
			cycles++;
			if (cycles == 90000) begin
				n_mismatch++;
				$display("mismatch run length expected end seen limit");
				test_done();
			end
		end
	end

	// Main sequence: rail off first, then the bus-silence fail-safe
	initial begin
		n_mismatch = 0;
		num_checks = 0;
		sys_rst <= 1'b1;
		core_voltage_rail <= 1'b0;
		temp_code <= 8'h00;
		pin_ext <= 1'b1;
		cyc(4);
		sys_rst <= 1'b0;
		cyc(8);
		check("fans after reset", 8'h00, 8'(fan_drive));
		check("data drive level", 8'h00, 8'(smb_sda_out));
		host.write_reg(7'h2F, `REG_EXT_CFG, 8'h01, ok);
		check("foreign address ack", 8'h00, 8'(ok));
		check("monitor idle", 8'h00, 8'(monitor_go_bit));
		rdc(`REG_EXT_CFG, 8'hFF, `RST_EXT_CFG);
		cyc(10);
		check("monitor after transaction", 8'h01, 8'(monitor_go_bit));
		cyc(FS + 50);
		check("fans without rail", 8'h00, 8'(fan_drive));
		rdc(`REG_STATUS2, 8'h02, 8'h00);
		rdc(`REG_PIN_FN, 8'hFF, `RST_PIN_FN);
		rdc(`REG_THERMAL_LIMIT_PIN_LIMIT, 8'hFF, `RST_THERMAL_LIMIT_PIN_LIMIT);
		rdc(`REG_MAX_DUTY, 8'hFF, `RST_MAX_DUTY);
		wr(8'h01, 8'h55);
		rdc(8'h01, 8'hFF, 8'h00);
		wr(`REG_EXT_CFG, 8'hFF);
		rdc(`REG_EXT_CFG, 8'hFF, 8'h1F);
		for (int f = 0; f < 4; f++) begin
			wr(`REG_PIN_FN, 8'(f));
			rdc(`REG_PIN_FN, 8'hFF, 8'(f));
		end
		for (int i = 0; i < 4; i++) begin
			wr(`REG_EXT_CFG, gcfg[i]);
			check("gpio drive", 8'(goe[i]), 8'(shared_pin_oe));
		end
		wr(`REG_EXT_CFG, 8'h00);
		for (int k = 0; k < 4; k++) begin
			wr(`REG_PIN_FN, 8'(k / 2));
			@(posedge clk_sys);
			pin_ext <= k[0];
			cyc(8);
			check("tach input", 8'(k < 2 && k[0]), 8'(fan4_speed_input));
			check("hot signal", 8'(k == 2), 8'(processor_hot_signal));
			if (k < 2) rdc(`REG_STATUS2, 8'h20, {2'b00, k[0], 5'b00000});
		end
		wr(`REG_FAN_DUTY0, 8'h80);
		watch_fan(6000);
		check("fast drive", 8'h01, 8'(tr >= 2 && hi > 2000 && hi < 3600));
		wr(`REG_MAX_DUTY, 8'h40);
		watch_fan(6000);
		check("duty clamp", 8'h01, 8'(hi > 900 && hi < 2100));
		wr(`REG_MAX_DUTY, 8'hFF);
		wr(`REG_LF_FREQ, 8'h0A);
		wr(`REG_EXT_CFG, 8'h02);
		watch_fan(6000);
		check("slow drive", 8'h01, 8'(tr <= 1));
		wr(`REG_EXT_CFG, 8'h00);
		wr(`REG_THERMAL_LIMIT_PIN_LIMIT, 8'h50);
		temp_to(8'h50);
		rdc(`REG_STATUS2, 8'h01, 8'h00);
		temp_to(8'h51);
		rdc(`REG_STATUS2, 8'h01, 8'h01);
		watch_fan(100);
		check("overtemp drive", 8'h07, 8'(hi == 100 ? fan_drive : 3'b000));
		temp_to(8'hA5);
		wr(`REG_EXT_CFG, 8'h01);
		rdc(`REG_STATUS2, 8'h01, 8'h00);
		wr(`REG_EXT_CFG, 8'h00);
		rdc(`REG_STATUS2, 8'h01, 8'h01);
		temp_to(8'h50);
		wr(`REG_TEMP_OFFSET, 8'h02);
		rdc(`REG_STATUS2, 8'h01, 8'h01);
		rdc(`REG_TEMP_OFFSET, 8'hFF, 8'h02);
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		core_voltage_rail <= 1'b1;
		temp_code <= 8'h00;
		cyc(4);
		sys_rst <= 1'b0;
		cyc(FS - 20);
		check("fans before silence limit", 8'h00, 8'(fan_drive));
		check("monitor on rail", 8'h01, 8'(monitor_go_bit));
		cyc(40);
		check("silence full drive", 8'h07, 8'(fan_drive));
		rdc(`REG_STATUS2, 8'h02, 8'h02);
		wr(`REG_FAN_DUTY0, 8'h00);
		cyc(8);
		check("programmed after fail-safe", 8'h00, 8'(fan_drive));
		test_done();
	end
endmodule : test_fan_monitor_config_failsafe
